// ===== verification/bus_master_model.sv
// bus master model standing in for the processor or cache controller
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
    import sram_pkg::*;
(
    input wire logic clock,
    output var bus_in_t bus,
    output logic output_enable_n,
    output logic sleep_request,
    output logic burst_order_select
);
    // task-side copies of the outputs; the tasks write these, the ports follow them
    bus_in_t bus_drv;
    logic oe_n_drv;
    logic sleep_drv;
    logic order_drv;

    assign bus = bus_drv;
    assign output_enable_n = oe_n_drv;
    assign sleep_request = sleep_drv;
    assign burst_order_select = order_drv;

    ////////////////////////////////////////////////////////////////////////////////
    // idle bus: selects and strobes inactive, write controls high
    function automatic bus_in_t quiet();
        quiet = '{16'h0000, 32'h5A5A5A5A, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 1'b1, 1'b0, 1'b1};
    endfunction

    // one selected cycle; sav = strobes and advance, wr = global, byte enable, lanes
    function automatic bus_in_t cyc(input logic [15:0] a, input logic [2:0] sav, input logic [5:0] wr,
                                    input logic [31:0] d);
        cyc = '{a, d, sav[2], sav[1], sav[0], wr[5], wr[4], wr[3:0], 1'b0, 1'b1, 1'b0};
    endfunction

    initial begin
        bus_drv = quiet();
        oe_n_drv = 1'b0;
        sleep_drv = 1'b0;
        order_drv = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one cycle, launched just after the edge; undriven data keeps toggling
    // so a stale value on the wire can never pass for read data
    task automatic beat(input bus_in_t b);
        @(posedge clock);
        #5;
        if (b.global_write_n && b.byte_write_enable_n) begin
            b.wdata = ~bus_drv.wdata;
        end
        bus_drv = b;
    endtask

    // strobe with at least one select inactive leaves the selected state
    task automatic deselect();
        bus_in_t b;
        b = quiet();
        b.controller_addr_strobe_n = 1'b0;
        // pick the inactive selects at random: all three, the second alone or the third alone
        case ($urandom_range(2))
            0: begin
                b.chip_select_first_n = 1'b1;
            end
            1: begin
                b.chip_select_first_n = 1'b0;
                b.chip_select_third_n = 1'b0;
            end
            default: begin
                b.chip_select_first_n = 1'b0;
                b.chip_select_second = 1'b1;
            end
        endcase
        beat(b);
    endtask

    task automatic idle(input int n);
        repeat (n) beat(quiet());
    endtask

    // output enable passes a synchroniser, so give it time to land
    task automatic set_oe(input logic v);
        beat(quiet());
        oe_n_drv = v;
        idle(3);
    endtask

    // the strap only moves while deselected and is then left alone
    task automatic set_mode(input logic v);
        deselect();
        order_drv = v;
        idle(4);
    endtask

    // no strobe may stand in the cycle after sleep drops, so wake starts quiet
    task automatic set_sleep(input logic v);
        if (v) begin
            deselect();
        end else begin
            beat(quiet());
        end
        sleep_drv = v;
    endtask
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// self-checking testbench for the pipelined burst sram interface
`timescale 1ns/1ps
`default_nettype none
module testbench
    import sram_pkg::*;
;
    logic clock;
    logic rst;
    bus_in_t bus;
    logic output_enable_n;
    logic sleep_request;
    logic burst_order_select;
    logic [31:0] data_in;
    logic [31:0] data_out;
    logic data_oe;
    logic sleep_active;
    logic [31:0] exp_q[$];
    logic [31:0] mem[logic [15:0]];
    int n_errors = 0;
    int checks = 0;

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    bus_master_model m (.clock(clock), .bus(bus), .output_enable_n(output_enable_n),
        .sleep_request(sleep_request), .burst_order_select(burst_order_select));

    // shared data wire: the device when it drives, else the master
    assign data_in = data_oe ? data_out : bus.wdata;

    pipelined_burst_sram_interface uut (.clock(clock), .rst(rst), .address(bus.addr),
        .processor_addr_strobe_n(bus.processor_addr_strobe_n),
        .controller_addr_strobe_n(bus.controller_addr_strobe_n), .burst_advance_n(bus.burst_advance_n),
        .global_write_n(bus.global_write_n), .byte_write_enable_n(bus.byte_write_enable_n),
        .byte_lane_select_n(bus.byte_lane_select_n), .chip_select_first_n(bus.chip_select_first_n),
        .chip_select_second(bus.chip_select_second), .chip_select_third_n(bus.chip_select_third_n),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .burst_order_select(burst_order_select), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .sleep_active(sleep_active));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic report_and_stop();
        $display("mismatches %0d, comparisons %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reference copy of the array, lane by lane
    task automatic note(input logic [15:0] a, input logic [5:0] wr, input logic [31:0] d);
        for (int l = 0; l < 4; l++) begin
            if (!wr[5] || (!wr[4] && !wr[l])) begin
                mem[a][8*l +: 8] = d[8*l +: 8];
            end
        end
    endtask

    // controller-strobe write, advance held low to show it is ignored
    task automatic wr_c(input logic [15:0] a, input logic [5:0] wr, input logic [31:0] d);
        m.beat(m.cyc(a, 3'b100, wr, d));
        m.deselect();
        note(a, wr, d);
    endtask

    // processor-strobe write: first cycle carries bogus controls and advance
    task automatic wr_p(input logic [15:0] a, input logic [5:0] wr, input logic [31:0] d);
        m.beat(m.cyc(a, 3'b010, 6'h00, ~d));
        m.beat(m.cyc(16'($urandom), 3'b111, wr, d));
        m.deselect();
        note(a, wr, d);
    endtask

    // two back-to-back reads; the first after deselect stays off the bus
    task automatic rd(input logic [15:0] a, input logic [15:0] b);
        m.beat(m.cyc(a, 3'b101, 6'h3F, 32'h0));
        m.beat(m.cyc(b, 3'b101, 6'h3F, 32'h0));
        exp_q.push_back(mem[b]);
        m.deselect();
    endtask

    // four-beat read burst; addresses on advance beats are junk on purpose
    task automatic burst(input logic [15:0] a, input logic ord, input logic oe_n);
        bus_in_t b;
        logic [1:0] s;
        m.beat(m.cyc(a, 3'b011, 6'h3F, 32'h0));
        for (int k = 1; k < 4; k++) begin
            b = m.cyc(16'($urandom), 3'b110, 6'h3F, 32'h0);
            if (k == 2) begin
                b.processor_addr_strobe_n = 1'b0;
                b.chip_select_first_n = 1'b1;
            end
            m.beat(b);
            s = ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
            if (!oe_n) begin
                exp_q.push_back(mem[{a[15:2], s}]);
            end
        end
        m.deselect();
        m.idle(2);
        check(32'(exp_q.size()), 32'h0);
    endtask

    // bounded wait for the sleep flag; entry and exit are never instant
    task automatic wait_sleep(input logic v);
        int i;
        for (i = 0; i < 12 && sleep_active !== v; i++) begin
            @(posedge clock);
            #1;
        end
        if (sleep_active !== v) begin
            n_errors++;
            report_and_stop();
        end
        check({31'h0, i >= 2}, 32'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // each driven beat must match the oldest expectation, else it is unwanted
    always @(negedge clock) begin
        if (!rst && data_oe !== 1'b0) begin
            if (exp_q.size() == 0) begin
                check({31'h0, data_oe}, 32'h0);
            end else begin
                check(data_out, exp_q.pop_front());
            end
        end
    end

    initial begin
        rst = 1'b1;
        void'($urandom(32'hfa4c7e02));
        repeat (4) @(posedge clock);
        #5;
        rst = 1'b0;
        m.set_oe(1'b1);
        for (int i = 0; i < 8; i++) begin
            wr_c(16'h0040 + 16'(i), 6'h1F, $urandom());
        end
        // every byte-enable and lane combination on one word
        for (int i = 0; i < 32; i++) begin
            m.set_oe(1'b1);
            wr_c(16'h0041, {1'b1, 5'(i)}, $urandom());
            m.set_oe(1'b0);
            rd(16'h0042, 16'h0041);
        end
        for (int i = 0; i < 17; i++) begin
            m.set_oe(1'b1);
            wr_p(16'h0044, (i == 16) ? 6'h1F : {2'b10, 4'(i)}, $urandom());
            m.set_oe(1'b0);
            rd(16'h0045, 16'h0044);
        end
        // both strobes low: processor start wins, so no write lands
        m.set_oe(1'b1);
        m.beat(m.cyc(16'h0046, 3'b001, 6'h1F, $urandom()));
        m.deselect();
        m.set_oe(1'b0);
        rd(16'h0047, 16'h0046);
        for (int j = 0; j < 9; j++) begin
            m.set_mode(j[2]);
            m.set_oe(j == 8);
            burst(16'h0040 | 16'(j[1:0]) | (j[0] ? 16'h0004 : 16'h0000), j[2], j == 8);
        end
        // sleep: an access while asleep is dropped and the array is kept
        m.set_oe(1'b1);
        m.set_sleep(1'b1);
        wait_sleep(1'b1);
        m.beat(m.cyc(16'h0043, 3'b100, 6'h1F, ~mem[16'h0043]));
        m.set_sleep(1'b0);
        wait_sleep(1'b0);
        m.idle(4);
        m.set_oe(1'b0);
        rd(16'h0043, 16'h0043);
        m.idle(3);
        check(32'(exp_q.size()), 32'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire

// ===== verilog/burst_counter.sv
// two-bit wraparound burst address counter, linear or interleaved
`timescale 1ns/1ps
`default_nettype none
`include "sram_defs.svh"
module burst_counter
    import sram_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic advance,
    input wire logic interleaved,
    input wire logic [`BURST_W-1:0] start_value,
    output logic [`BURST_W-1:0] base,
    output logic [`BURST_W-1:0] cur,
    output logic [`BURST_W-1:0] nxt
);
    logic [`BURST_W-1:0] base_r;
    logic [`BURST_W-1:0] step_r;

    // keeping base and step apart makes both orders a plain function
    always_ff @(posedge clock) begin
        if (rst) begin
            base_r <= '0;
            step_r <= '0;
        end else if (load) begin
            base_r <= start_value;
            step_r <= '0;
        end else if (advance) begin
            step_r <= `BURST_W'(step_r + 2'h1);
        end
    end

    assign base = base_r;
    assign cur = seq_addr(base_r, step_r, interleaved);
    assign nxt = seq_addr(base_r, `BURST_W'(step_r + 2'h1), interleaved);
endmodule
`default_nettype wire

// ===== verilog/pipelined_burst_sram_interface.sv
// pipelined burst cache sram: bus decode, burst control, sleep and output drive
// Functional notes
// - all synchronous inputs are captured in input registers on the rising edge.
// - read data leaves the output register one clock after the address edge.
// - burst order comes from sampling the burst-order select input.
// - either strobe starts an access; processor strobe ignored while first select high.
// - access start loads the low two address bits into the burst counter.
// - advance low at an edge steps the counter, for reads and writes.
// - interleaved order: start xor 00, 01, 10, 11.
// - linear order: previous value plus one, modulo four.
// - byte writes need byte enable and lane selects; global write writes all.
// - lanes not selected in a byte write stay unchanged.
// - read starts on a strobe with all selects active and no write controls.
// - first cycle after leaving deselect keeps outputs off regardless of enable.
// - a deselecting strobe edge turns the data outputs off one clock later.
// - processor-strobe write ignores write controls and advance on its first cycle.
// - processor-strobe write completes at the second edge with its write controls.
// - controller-strobe write completes in one cycle and ignores advance.
// - data drivers are off whenever a write cycle is detected.
// - sleep input enters low-power sleep in two cycles, keeps the array.
// - accesses pending at sleep entry are dropped as invalid.
// - select low means linear, high means interleaved; kept static.
// - with both strobes low and first select low only the processor strobe counts.
// - write means global write low, or byte enable low with a lane selected.
// - output enable is active low; high turns the data pins into inputs.
`timescale 1ns/1ps
`default_nettype none
`include "sram_defs.svh"
module pipelined_burst_sram_interface
    import sram_pkg::*;
#(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int DATA_W = `SRAM_DATA_W,
    parameter int LANES = `SRAM_LANES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] address,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [LANES-1:0] byte_lane_select_n,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic burst_order_select,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output logic sleep_active
);
    localparam int ENTRY_CYC = `SLEEP_ENTRY_TIME_CYC;
    localparam int RECOVERY_CYC = `SLEEP_RECOVERY_TIME_CYC;
    localparam logic [1:0] ENTRY_LAST = 2'(ENTRY_CYC - 1);
    localparam logic [1:0] RECOVERY_LAST = 2'(RECOVERY_CYC - 1);

    ////////////////////////////////////////////////////////////////////////////
    // input registers and pin synchronisers

    bus_in_t in_r;
    logic sleep_meta_r, sleep_sync_r;
    logic oe_meta_r, oe_sync_n_r;
    logic order_meta_r, order_r;

    // every synchronous pin is sampled once, at the rising edge
    always_ff @(posedge clock) begin
        if (rst) begin
            in_r <= '{addr: '0, wdata: '0, processor_addr_strobe_n: 1'b1,
                      controller_addr_strobe_n: 1'b1, burst_advance_n: 1'b1,
                      global_write_n: 1'b1, byte_write_enable_n: 1'b1,
                      byte_lane_select_n: `ALL_LANES, chip_select_first_n: 1'b1,
                      chip_select_second: 1'b0, chip_select_third_n: 1'b1};
        end else begin
            in_r <= '{addr: address, wdata: data_in,
                      processor_addr_strobe_n: processor_addr_strobe_n,
                      controller_addr_strobe_n: controller_addr_strobe_n,
                      burst_advance_n: burst_advance_n, global_write_n: global_write_n,
                      byte_write_enable_n: byte_write_enable_n,
                      byte_lane_select_n: byte_lane_select_n,
                      chip_select_first_n: chip_select_first_n,
                      chip_select_second: chip_select_second,
                      chip_select_third_n: chip_select_third_n};
        end
    end

    // asynchronous pins: sleep, output enable and the order strap
    always_ff @(posedge clock) begin
        if (rst) begin
            sleep_meta_r <= 1'b0;
            sleep_sync_r <= 1'b0;
            oe_meta_r <= 1'b1;
            oe_sync_n_r <= 1'b1;
            order_meta_r <= `ORDER_INTERLEAVED;
            order_r <= `ORDER_INTERLEAVED;
        end else begin
            sleep_meta_r <= sleep_request;
            sleep_sync_r <= sleep_meta_r;
            oe_meta_r <= output_enable_n;
            oe_sync_n_r <= oe_meta_r;
            order_meta_r <= burst_order_select;
            order_r <= order_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sleep control

    sleep_state_t sleep_state_r, sleep_state_nxt;
    logic [1:0] sleep_cnt_r, sleep_cnt_nxt;
    logic awake_ok;

    // entry and exit each take a fixed count of cycles
    always_comb begin
        sleep_state_nxt = sleep_state_r;
        sleep_cnt_nxt = sleep_cnt_r;
        case (sleep_state_r)
            ST_AWAKE: begin
                if (sleep_sync_r) begin
                    sleep_state_nxt = ST_ENTER;
                    sleep_cnt_nxt = 2'h0;
                end
            end
            ST_ENTER: begin
                if (sleep_cnt_r == ENTRY_LAST) begin
                    sleep_state_nxt = ST_ASLEEP;
                end else begin
                    sleep_cnt_nxt = 2'(sleep_cnt_r + 2'h1);
                end
            end
            ST_ASLEEP: begin
                if (!sleep_sync_r) begin
                    sleep_state_nxt = ST_WAKE;
                    sleep_cnt_nxt = 2'h0;
                end
            end
            ST_WAKE: begin
                if (sleep_cnt_r == RECOVERY_LAST) begin
                    sleep_state_nxt = ST_AWAKE;
                end else begin
                    sleep_cnt_nxt = 2'(sleep_cnt_r + 2'h1);
                end
            end
            default: begin
                sleep_state_nxt = ST_AWAKE;
                sleep_cnt_nxt = 2'h0;
            end
        endcase
    end

    // sleep state registers and the visible sleep flag
    always_ff @(posedge clock) begin
        if (rst) begin
            sleep_state_r <= ST_AWAKE;
            sleep_cnt_r <= 2'h0;
            sleep_active <= 1'b0;
        end else begin
            sleep_state_r <= sleep_state_nxt;
            sleep_cnt_r <= sleep_cnt_nxt;
            sleep_active <= (sleep_state_nxt == ST_ASLEEP);
        end
    end

    // a sleep request already seen kills whatever access is in flight
    assign awake_ok = (sleep_state_r == ST_AWAKE) && !sleep_sync_r;

    ////////////////////////////////////////////////////////////////////////////
    // cycle decode

    logic cs_all, p_strobe, c_strobe, any_strobe;
    logic start, desel, cont, wr_ctl, wr_op, rd_op, first_cycle;
    logic selected_r;
    logic [LANES-1:0] wr_mask;

    assign cs_all = !in_r.chip_select_first_n && in_r.chip_select_second && !in_r.chip_select_third_n;
    assign p_strobe = !in_r.processor_addr_strobe_n && !in_r.chip_select_first_n;
    assign c_strobe = !in_r.controller_addr_strobe_n && !p_strobe;
    assign any_strobe = p_strobe || c_strobe;
    assign start = awake_ok && any_strobe && cs_all;
    assign desel = awake_ok && any_strobe && !cs_all;
    assign cont = awake_ok && !any_strobe && selected_r;
    assign wr_mask = lane_mask(in_r.global_write_n, in_r.byte_write_enable_n,
                               in_r.byte_lane_select_n);
    assign wr_ctl = |wr_mask;
    // processor strobe opens as a read; its write lands on the next edge
    assign wr_op = (start && c_strobe && wr_ctl) || (cont && wr_ctl);
    assign rd_op = (start && (p_strobe || !wr_ctl)) || (cont && !wr_ctl);
    assign first_cycle = start && !selected_r;

    // selection follows strobes; sleep drops it
    always_ff @(posedge clock) begin
        if (rst || !awake_ok) begin
            selected_r <= 1'b0;
        end else if (start) begin
            selected_r <= 1'b1;
        end else if (desel) begin
            selected_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address path and burst counter

    logic [ADDR_W-1:2] addr_hi_r;
    logic [`BURST_W-1:0] ctr_base, ctr_cur, ctr_nxt, addr_lo;
    logic ctr_adv;
    logic [ADDR_W-1:0] mem_addr;

    // advance is not looked at on a start edge
    assign ctr_adv = cont && !in_r.burst_advance_n;
    assign addr_lo = start ? in_r.addr[1:0] : (ctr_adv ? ctr_nxt : ctr_cur);
    assign mem_addr = {(start ? in_r.addr[ADDR_W-1:2] : addr_hi_r), addr_lo};

    // upper address bits held for the whole burst
    always_ff @(posedge clock) begin
        if (rst) begin
            addr_hi_r <= '0;
        end else if (start) begin
            addr_hi_r <= in_r.addr[ADDR_W-1:2];
        end
    end

    burst_counter u_counter (
        .clock(clock),
        .rst(rst),
        .load(start),
        .advance(ctr_adv),
        .interleaved(order_r),
        .start_value(in_r.addr[1:0]),
        .base(ctr_base),
        .cur(ctr_cur),
        .nxt(ctr_nxt)
    );

    ////////////////////////////////////////////////////////////////////////////
    // array and output drive

    sram_array #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .LANES(LANES)
    ) u_array (
        .clock(clock),
        .rst(rst),
        .rd_en(rd_op),
        .wr_lanes(wr_op ? wr_mask : `NO_LANES),
        .addr(mem_addr),
        .wr_data(in_r.wdata),
        .rd_data(data_out)
    );

    // enable is re-evaluated every edge; writes and fresh selects never drive
    always_ff @(posedge clock) begin
        if (rst) begin
            data_oe <= 1'b0;
        end else begin
            data_oe <= rd_op && !first_cycle && !oe_sync_n_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_read_drive: assert property (rd_op && !first_cycle && !oe_sync_n_r |=> data_oe)
        else $error("read with enable did not drive next cycle");
    a_write_hiz: assert property (wr_op |=> !data_oe)
        else $error("data driven after a write cycle");
    a_first_masked: assert property (start && !selected_r |=> !data_oe && selected_r)
        else $error("first cycle after deselect drove data");
    a_deselect_hiz: assert property (desel |=> !data_oe && !selected_r)
        else $error("deselect did not turn outputs off");
    a_pstrobe_no_write: assert property (start && p_strobe |-> !wr_op && rd_op)
        else $error("processor strobe start wrote on first cycle");
    a_counter_load: assert property (start |=> ctr_cur == $past(in_r.addr[1:0]))
        else $error("burst counter not loaded on start");
    a_linear_step: assert property (ctr_adv && !order_r |-> ctr_nxt == 2'(ctr_cur + 2'h1))
        else $error("linear burst step wrong");
    a_interleave_step: assert property (ctr_adv && order_r |->
        (ctr_nxt ^ ctr_cur) == (((ctr_cur ^ ctr_base) & 2'h1) != 2'h0 ? 2'h3 : 2'h1))
        else $error("interleaved burst step wrong");
    a_advance_moves: assert property (ctr_adv |=> ctr_cur == $past(ctr_nxt))
        else $error("advance did not step the counter");
    a_byte_mask: assert property (wr_op && in_r.global_write_n |-> wr_mask == ~in_r.byte_lane_select_n)
        else $error("byte lane mask wrong");
    a_sleep_entry: assert property (sleep_state_r == ST_AWAKE && sleep_sync_r ##1 sleep_sync_r[*2]
        |=> sleep_active)
        else $error("sleep not entered two cycles after request");
    a_sleep_blocks: assert property (!awake_ok |-> !rd_op && !wr_op ##1 !data_oe)
        else $error("access ran while sleeping");
endmodule
`default_nettype wire

// ===== verilog/sram_array.sv
// byte-writable storage array with a registered read port
`timescale 1ns/1ps
`default_nettype none
`include "sram_defs.svh"
module sram_array #(
    parameter int ADDR_W = `SRAM_ADDR_W,
    parameter int DATA_W = `SRAM_DATA_W,
    parameter int LANES = `SRAM_LANES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic rd_en,
    input wire logic [LANES-1:0] wr_lanes,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] rd_data
);
    localparam int LANE_W = DATA_W / LANES;

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // only the selected lanes change, the rest keep their contents
    always_ff @(posedge clock) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_lanes[i]) begin
                mem[addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
            end
        end
    end

    // read data register; held between reads so the output pipe stays stable
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem[addr];
        end
    end
endmodule
`default_nettype wire

// ===== verilog/sram_defs.svh
// constants for the pipelined burst sram interface
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

`define SRAM_ADDR_W 16
`define SRAM_DATA_W 32
`define SRAM_LANES 4
`define BURST_W 2
`define ALL_LANES 4'hF
`define NO_LANES 4'h0
`define ORDER_LINEAR 1'b0
`define ORDER_INTERLEAVED 1'b1
`define CLOCK_PERIOD_NS 50
// sleep entry and recovery are specified in clock periods
`define SLEEP_ENTRY_TIME_CYC 2
`define SLEEP_RECOVERY_TIME_CYC 2

`endif

// ===== verilog/sram_pkg.sv
// types and decode functions shared by the sram interface files
`default_nettype none
`include "sram_defs.svh"
package sram_pkg;

    // one sampled set of the synchronous bus pins
    typedef struct packed {
        logic [`SRAM_ADDR_W-1:0] addr;
        logic [`SRAM_DATA_W-1:0] wdata;
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_advance_n;
        logic global_write_n;
        logic byte_write_enable_n;
        logic [`SRAM_LANES-1:0] byte_lane_select_n;
        logic chip_select_first_n;
        logic chip_select_second;
        logic chip_select_third_n;
    } bus_in_t;

    typedef enum logic [1:0] {
        ST_AWAKE = 2'b00,
        ST_ENTER = 2'b01,
        ST_ASLEEP = 2'b10,
        ST_WAKE = 2'b11
    } sleep_state_t;

    // global write forces all lanes, else byte enable qualifies the selects
    function automatic logic [`SRAM_LANES-1:0] lane_mask(input logic gw_n, input logic bwe_n,
                                                        input logic [`SRAM_LANES-1:0] bw_n);
        lane_mask = `NO_LANES;
        if (!gw_n) begin
            lane_mask = `ALL_LANES;
        end else if (!bwe_n) begin
            lane_mask = ~bw_n;
        end
    endfunction

    // low address bits of a burst beat from its base and step count
    function automatic logic [`BURST_W-1:0] seq_addr(input logic [`BURST_W-1:0] base,
                                                    input logic [`BURST_W-1:0] step,
                                                    input logic interleaved);
        if (interleaved) begin
            seq_addr = base ^ step;
        end else begin
            seq_addr = `BURST_W'(base + step);
        end
    endfunction

endpackage
`default_nettype wire
